// ---- verilog/cplmc_map.vh ----
// Register map, field positions and reset values of the logic cell block
`ifndef CPLMC_MAP_VH
`define CPLMC_MAP_VH
// ====================================================================
// Register byte offsets
`define CPLMC_CTRL_OFS      12'h000
`define CPLMC_TERMSEL_OFS   12'h004
`define CPLMC_STATUS_OFS    12'h008
`define CPLMC_SIGN_OFS      12'h00c
`define CPLMC_FUSE_OFS      12'h010
`define CPLMC_SWM_BASE      12'h040
`define CPLMC_MASK_BASE     12'h100
// ====================================================================
// Control register fields (low bit only)
`define CPLMC_XOR_SEL       0
`define CPLMC_D_SEL         2
`define CPLMC_MODE          4
`define CPLMC_CLK_SEL       7
`define CPLMC_CE_EN         9
`define CPLMC_CLR_SEL       10
`define CPLMC_SET_EN        12
`define CPLMC_OUT_REG       13
`define CPLMC_FB_REG        14
`define CPLMC_OE_SEL        15
`define CPLMC_CASC_EN       18
`define CPLMC_KEEP_EN       19
`define CPLMC_IO_DIR        20
`define CPLMC_OE_IDX        22
`define CPLMC_CTRL_MASK     32'h1fffffff
`define CPLMC_CTRL_RST      32'h00000000
// ====================================================================
// Term select register fields
`define CPLMC_SUM_MASK      0
`define CPLMC_XOR_T         5
`define CPLMC_D_T           8
`define CPLMC_CLK_T         11
`define CPLMC_CE_T          14
`define CPLMC_CLR_T         17
`define CPLMC_SET_T         20
`define CPLMC_FOLD_T        23
`define CPLMC_TERMSEL_MASK  32'h03ffffff
`define CPLMC_TERMSEL_RST   32'h0000001f
// ====================================================================
// Encodings
`define CPLMC_MODE_D        3'h0
`define CPLMC_MODE_T        3'h1
`define CPLMC_MODE_JK       3'h2
`define CPLMC_MODE_SR       3'h3
`define CPLMC_MODE_LATCH    3'h4
`define CPLMC_SIGN_RST      16'h0000
`define CPLMC_SWM_ENTRIES   40
`define CPLMC_MASK_WORDS    20
`endif

// ---- verilog/cplmc_core.v ----
// One configurable logic cell with switch matrix, keeper and APB configuration port
//
// Notes on behaviour
// (RULE_01) Five product terms over global and regional inputs
// (RULE_02) Chain input extends the sum term
// (RULE_03) XOR second input: term, high or low
// (RULE_04) Data from XOR, separate term or pin
// (RULE_05) D, T, JK, SR and transparent latch
// (RULE_06) Clock: three shared edges or a term
// (RULE_07) Low enable term blocks shared edges
// (RULE_08) Clear: shared line, term, both, none
// (RULE_09) Set: a term or never
// (RULE_10) Output and feedback pick registered independently
// (RULE_11) Drive enable from pins, inverted, or cells
// (RULE_12) Input, output or bidirectional; logic still usable
// (RULE_13) Switch matrix picks forty global bus signals
// (RULE_14) Inverted term drives the regional bus
// (RULE_15) Shared pins serve as clock, clear, enable
// (RULE_16) Keeper holds the last driven pin level
// (RULE_17) Sixteen bit signature always readable
// (RULE_18) Programmed fuse hides configuration from reads
// (RULE_19) Clear wins over set
`timescale 1ns/1ps
`include "cplmc_map.vh"

module cplmc_core #(
	parameter GBUS_W = 68,
	parameter SEL_W  = 7
) (
	input  wire              clk_sys,
	input  wire              sys_rst,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [11:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	input  wire [GBUS_W-1:0] gbus,
	input  wire [3:0]        region_in,
	input  wire              chain_sum_input,
	input  wire [2:0]        shared_edge_source,
	input  wire              shared_clear_line,
	input  wire [1:0]        oe_pin,
	input  wire              pad_i,
	input  wire              pad_ext_drv,
	output reg               pad_o,
	output reg               pad_oe,
	output reg               pad_keep_o,
	output reg               pad_keep_oe,
	output reg               fb_out,
	output reg               fold_out,
	output reg               chain_sum_output
);

	// ====================================================================
	// Helpers
	// Picks one of the five terms; indices above four read as low
	function pick;
		input [4:0] terms;
		input [2:0] idx;
		begin
			pick = (idx < 3'd5) ? terms[idx] : 1'b0;
		end
	endfunction

	// Product term: every input with a true or complement bit set must match
	function pterm;
		input [43:0] v;
		input [43:0] tm;
		input [43:0] cm;
		begin
			pterm = (&(~tm | v)) & (&(~cm | ~v)) & (|(tm | cm));
		end
	endfunction

	// ====================================================================
	// Configuration storage
	reg  [31:0]      ctrl;
	reg  [31:0]      termsel;
	reg  [15:0]      sign;
	reg              fuse;
	reg  [SEL_W-1:0] swm [0:`CPLMC_SWM_ENTRIES-1];
	reg  [31:0]      mask_mem [0:`CPLMC_MASK_WORDS-1];
	reg              q;
	reg              clk_prev;
	reg              pin_level;
	integer          i;

	wire [1:0]       xor_sel  = ctrl[`CPLMC_XOR_SEL+:2];
	wire [1:0]       d_sel    = ctrl[`CPLMC_D_SEL+:2];
	wire [2:0]       mode     = ctrl[`CPLMC_MODE+:3];
	wire [1:0]       clk_sel  = ctrl[`CPLMC_CLK_SEL+:2];
	wire             ce_en    = ctrl[`CPLMC_CE_EN];
	wire [1:0]       clr_sel  = ctrl[`CPLMC_CLR_SEL+:2];
	wire             set_en   = ctrl[`CPLMC_SET_EN];
	wire             out_reg  = ctrl[`CPLMC_OUT_REG];
	wire             fb_reg   = ctrl[`CPLMC_FB_REG];
	wire [2:0]       oe_sel   = ctrl[`CPLMC_OE_SEL+:3];
	wire             casc_en  = ctrl[`CPLMC_CASC_EN];
	wire             keep_en  = ctrl[`CPLMC_KEEP_EN];
	wire [1:0]       io_dir   = ctrl[`CPLMC_IO_DIR+:2];
	wire [SEL_W-1:0] oe_idx   = ctrl[`CPLMC_OE_IDX+:SEL_W];
	wire [4:0]       sum_mask = termsel[`CPLMC_SUM_MASK+:5];

	// ====================================================================
	// APB decode
	wire       apb_setup  = psel & ~penable;
	wire       apb_commit = psel & penable & pready;
	wire       apb_wr     = apb_commit & pwrite;
	wire [5:0] swm_idx    = paddr[7:2] - 6'h10;
	wire [4:0] mask_idx   = paddr[6:2];
	wire       swm_hit    = (paddr[11:8] == 4'h0) && (paddr[7:2] >= 6'h10)
	                        && (paddr[7:2] < 6'h38) && (paddr[1:0] == 2'h0);
	wire       mask_hit   = (paddr[11:7] == 5'h02) && (mask_idx < 5'h14)
	                        && (paddr[1:0] == 2'h0);

	// ====================================================================
	// Switch matrix and product terms
	wire [39:0] blk_in;
	genvar g;
	generate
		for (g = 0; g < 40; g = g + 1) begin : g_swm
			// Out-of-range selections read low rather than X
			assign blk_in[g] = (swm[g] < GBUS_W) ? gbus[swm[g]] : 1'b0; // RULE_13
		end
	endgenerate

	wire [43:0] arr_in = {region_in, blk_in};
	wire [4:0]  pt;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_pt
			assign pt[g] = pterm(arr_in,
				{mask_mem[4*g+1][11:0], mask_mem[4*g]},
				{mask_mem[4*g+3][11:0], mask_mem[4*g+2]}); // RULE_01
		end
	endgenerate

	// ====================================================================
	// Sum, XOR and data path
	wire sum_or  = (|(pt & sum_mask)) | (casc_en & chain_sum_input); // RULE_01 RULE_02
	reg  xor_in;
	reg  d_in;
	always @* begin
		case (xor_sel) // RULE_03
			2'h0:    xor_in = 1'b0;
			2'h1:    xor_in = 1'b1;
			default: xor_in = pick(pt, termsel[`CPLMC_XOR_T+:3]);
		endcase
	end
	wire xor_out = sum_or ^ xor_in;
	wire k_term  = pick(pt, termsel[`CPLMC_D_T+:3]);

	// Data source; the pin path serves as a fast registered input
	always @* begin
		case (d_sel) // RULE_04
			2'h0:    d_in = xor_out;
			2'h1:    d_in = k_term;
			default: d_in = pin_level;
		endcase
	end

	// ====================================================================
	// Storage element controls
	wire use_term_clk = (clk_sel == 2'h3);
	wire clk_lvl      = use_term_clk ? pick(pt, termsel[`CPLMC_CLK_T+:3])
	                                 : shared_edge_source[clk_sel]; // RULE_06 RULE_15
	wire clk_rise     = clk_lvl & ~clk_prev;
	// Enable only applies with a shared clock
	wire ce_ok        = ~(ce_en & ~use_term_clk)
	                    | pick(pt, termsel[`CPLMC_CE_T+:3]); // RULE_07
	wire clr_term     = pick(pt, termsel[`CPLMC_CLR_T+:3]);
	reg  clr_act;
	always @* begin
		case (clr_sel) // RULE_08 RULE_15
			2'h0:    clr_act = 1'b0;
			2'h1:    clr_act = shared_clear_line;
			2'h2:    clr_act = clr_term;
			default: clr_act = shared_clear_line | clr_term;
		endcase
	end
	wire set_act = set_en & pick(pt, termsel[`CPLMC_SET_T+:3]); // RULE_09

	// Next state of the element for each operating mode
	reg next_q;
	always @* begin
		case (mode) // RULE_05
			`CPLMC_MODE_D:  next_q = d_in;
			`CPLMC_MODE_T:  next_q = q ^ d_in;
			`CPLMC_MODE_JK: next_q = (xor_out & ~q) | (~k_term & q);
			`CPLMC_MODE_SR: next_q = xor_out | (~k_term & q);
			default:        next_q = d_in;
		endcase
	end

	// Storage element; clear and set act at once but are sampled on clk_sys,
	// since the whole cell runs in one clock domain
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q        <= 1'b0;
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= clk_lvl;
			if (clr_act) begin
				q <= 1'b0; // RULE_19 RULE_08
			end else if (set_act) begin
				q <= 1'b1; // RULE_09
			end else if (mode == `CPLMC_MODE_LATCH) begin
				if (clk_lvl) begin
					q <= d_in; // RULE_05
				end
			end else if (clk_rise && ce_ok) begin
				q <= next_q; // RULE_06 RULE_07
			end
		end
	end

	// ====================================================================
	// Output enable selection
	reg oe_sel_lvl;
	reg next_oe;
	always @* begin
		case (oe_sel) // RULE_11 RULE_15
			3'h0:    oe_sel_lvl = oe_pin[0];
			3'h1:    oe_sel_lvl = ~oe_pin[0];
			3'h2:    oe_sel_lvl = oe_pin[1];
			3'h3:    oe_sel_lvl = ~oe_pin[1];
			3'h4:    oe_sel_lvl = (oe_idx < GBUS_W) ? gbus[oe_idx] : 1'b0;
			3'h5:    oe_sel_lvl = 1'b1;
			default: oe_sel_lvl = 1'b0;
		endcase
		case (io_dir) // RULE_12
			2'h0:    next_oe = 1'b0;
			2'h1:    next_oe = 1'b1;
			default: next_oe = oe_sel_lvl;
		endcase
	end

	// ====================================================================
	// Pad, feedback and bus outputs; all registered, so each trails its source by one cycle
	wire next_pad_o = out_reg ? q : xor_out; // RULE_10
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pad_o            <= 1'b0;
			pad_oe           <= 1'b0;
			fb_out           <= 1'b0;
			fold_out         <= 1'b1;
			chain_sum_output <= 1'b0;
			pin_level        <= 1'b0;
			pad_keep_o       <= 1'b0;
			pad_keep_oe      <= 1'b0;
		end else begin
			pad_o            <= next_pad_o;
			pad_oe           <= next_oe;
			fb_out           <= fb_reg ? q : xor_out; // RULE_10 RULE_12
			fold_out         <= ~pick(pt, termsel[`CPLMC_FOLD_T+:3]); // RULE_14
			chain_sum_output <= sum_or; // RULE_02
			// Last driven level; floating keeps the old value
			if (pad_oe) begin
				pin_level <= pad_o; // RULE_16
			end else if (pad_ext_drv) begin
				pin_level <= pad_i; // RULE_16
			end
			pad_keep_o  <= pad_oe ? pad_o : (pad_ext_drv ? pad_i : pin_level);
			// Weak hold only while nobody else drives the pin
			pad_keep_oe <= keep_en & ~next_oe & ~pad_ext_drv; // RULE_16
		end
	end

	// ====================================================================
	// Register read mux; configuration hides behind the fuse, signature does not
	reg [31:0] rd_val;
	reg        rd_ok;
	always @* begin
		rd_val = 32'h00000000;
		rd_ok  = 1'b1;
		if (swm_hit) begin
			rd_val = fuse ? 32'h00000000 : {{(32-SEL_W){1'b0}}, swm[swm_idx]}; // RULE_18
		end else if (mask_hit) begin
			rd_val = fuse ? 32'h00000000 : mask_mem[mask_idx]; // RULE_18
		end else begin
			case (paddr)
				`CPLMC_CTRL_OFS:    rd_val = fuse ? 32'h00000000 : ctrl; // RULE_18
				`CPLMC_TERMSEL_OFS: rd_val = fuse ? 32'h00000000 : termsel; // RULE_18
				`CPLMC_STATUS_OFS:  rd_val = {26'h0, fuse, pin_level, sum_or,
				                              xor_out, pt[0], q};
				`CPLMC_SIGN_OFS:    rd_val = {16'h0000, sign}; // RULE_17
				`CPLMC_FUSE_OFS:    rd_val = {31'h0, fuse};
				default:            rd_ok  = 1'b0;
			endcase
		end
	end

	// ====================================================================
	// APB slave: answer prepared in setup, access completes with no wait
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (apb_setup) begin
			pready  <= 1'b1;
			pslverr <= ~rd_ok;
			prdata  <= (rd_ok && !pwrite) ? rd_val : 32'h00000000;
		end else if (apb_commit) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

	// Register writes; configuration stays writable after the fuse
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl    <= `CPLMC_CTRL_RST;
			termsel <= `CPLMC_TERMSEL_RST;
			sign    <= `CPLMC_SIGN_RST;
			fuse    <= 1'b0;
			for (i = 0; i < `CPLMC_SWM_ENTRIES; i = i + 1) begin
				swm[i] <= {SEL_W{1'b0}};
			end
			for (i = 0; i < `CPLMC_MASK_WORDS; i = i + 1) begin
				mask_mem[i] <= 32'h00000000;
			end
		end else if (apb_wr) begin
			if (swm_hit) begin
				swm[swm_idx] <= pwdata[SEL_W-1:0]; // RULE_13
			end else if (mask_hit) begin
				mask_mem[mask_idx] <= pwdata; // RULE_01
			end else begin
				case (paddr)
					`CPLMC_CTRL_OFS:    ctrl    <= pwdata & `CPLMC_CTRL_MASK;
					`CPLMC_TERMSEL_OFS: termsel <= pwdata & `CPLMC_TERMSEL_MASK;
					`CPLMC_SIGN_OFS:    sign    <= pwdata[15:0]; // RULE_17
					// Fuse is one-way: only reset removes it
					`CPLMC_FUSE_OFS:    fuse    <= fuse | pwdata[0]; // RULE_18
					default:            fuse    <= fuse;
				endcase
			end
		end
	end

endmodule // cplmc_core

// ---- verification/cplmc_core_chk.sv ----
// Bus handshake checker for the logic cell configuration port
`timescale 1ns/1ps

module cplmc_core_chk (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr
);
	// ====================================================================
	// One clock domain, so clocking and reset are shared by every check
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// A setup cycle is always answered in the very next cycle
	AST_SETUP_READY:
		assert property (psel && !penable |=> pready) else $error("setup not answered");
	// Ready is a single cycle pulse
	AST_READY_ONE:
		assert property (pready |=> !pready) else $error("ready held too long");
	// Ready only answers an access phase
	AST_READY_ACCESS:
		assert property (pready |-> psel && penable) else $error("ready outside access");
	// A rising ready must follow a setup cycle
	AST_READY_CAUSE:
		assert property ($rose(pready) |-> $past(psel) && !$past(penable))
			else $error("ready without setup");
	// No select, no answer in the next cycle
	AST_IDLE_QUIET:
		assert property (!psel |=> !pready) else $error("ready while idle");
	// Error only comes with ready, and carries no data
	AST_ERR_READY:
		assert property (pslverr |-> pready) else $error("error without ready");
	AST_ERR_ZERO:
		assert property (pslverr |-> prdata == 32'h0) else $error("error with data");
	// The unmapped hole used by the bench must be refused
	AST_HOLE_ERR:
		assert property (pready && paddr == 12'h020 |-> pslverr) else $error("hole accepted");
	// The signature stays reachable whatever the fuse says
	AST_SIGN_OK:
		assert property (pready && paddr == 12'h00c |-> !pslverr) else $error("signature refused");
endmodule // cplmc_core_chk

// ---- verification/cplmc_core_bench.sv ----
// Self-checking bench for the configurable logic cell
`timescale 1ns/1ps
`include "cplmc_map.vh"

module cplmc_core_bench;
	reg         clk_sys = 1'b0;
	reg         sys_rst = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [67:0] gbus = 68'h0;
	reg  [3:0]  region_in = 4'h0;
	reg         chain_sum_input = 1'b0;
	reg  [2:0]  shared_edge_source = 3'h0;
	reg         shared_clear_line = 1'b0;
	reg  [1:0]  oe_pin = 2'h0;
	reg         pad_i = 1'b0;
	reg         pad_ext_drv = 1'b1;
	wire [31:0] prdata;
	wire        pready, pslverr, pad_o, pad_oe, pad_keep_o, pad_keep_oe;
	wire        fb_out, fold_out, chain_sum_output;
	reg  [32:0] exq[$];
	reg  [32:0] mkq[$];
	reg  [32:0] e, m;
	reg  [31:0] seed = 32'd11;
	reg  [31:0] sig;
	reg         a, b, xr, qv, fz;
	integer     errors = 0;
	integer     samples_checked = 0;
	integer     n;

	cplmc_core i_cplmc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .gbus(gbus),
		.region_in(region_in), .chain_sum_input(chain_sum_input),
		.shared_edge_source(shared_edge_source), .shared_clear_line(shared_clear_line),
		.oe_pin(oe_pin), .pad_i(pad_i), .pad_ext_drv(pad_ext_drv), .pad_o(pad_o),
		.pad_oe(pad_oe), .pad_keep_o(pad_keep_o), .pad_keep_oe(pad_keep_oe),
		.fb_out(fb_out), .fold_out(fold_out), .chain_sum_output(chain_sum_output));

	// ====================================================================
	// Helpers
	always #2 clk_sys = ~clk_sys;

	function automatic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		xs = seed;
	endfunction

	task check(input [32:0] seen, input [32:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Bus master: holds the request until ready is seen, bounded in case it never comes
	task apb(input w, input [11:0] ad, input [31:0] d, input [32:0] ex, input [32:0] mk);
		integer k;
		exq.push_back(ex);
		mkq.push_back(mk);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k = k + 1;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1)
			errors = errors + 1;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input [11:0] ad, input [31:0] d);
		apb(1'b1, ad, d, 33'h0, {1'b1, 32'h0});
	endtask

	task rd(input [11:0] ad, input [31:0] ex);
		apb(1'b0, ad, 32'h0, {1'b0, ex}, {33{1'b1}});
	endtask

	// Status word: fuse, pin level, sum, xor, term 0, stored bit
	task stat(input s, input x, input p, input q);
		rd(`CPLMC_STATUS_OFS, {26'h0, fz, 1'b0, s, x, p, q});
	endtask

	// Bus bit 0 feeds term 0, bus bit 5 feeds term 1; settle before any look
	task drive(input [31:0] v);
		a = v[0];
		b = v[5];
		gbus <= {v[3:0], v, v};
		region_in <= v[11:8];
		oe_pin <= v[13:12];
		repeat (3) @(posedge clk_sys);
	endtask

	task pulse;
		shared_edge_source[0] <= 1'b1;
		repeat (3) @(posedge clk_sys);
		shared_edge_source[0] <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	// Pin side outputs, looked at on the falling edge once they have settled:
	// pad_o, pad_oe, pad_keep_o, pad_keep_oe, fb_out, fold_out, chain_sum_output
	task look(input [6:0] ex);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		check({pad_o, pad_oe, pad_keep_o, pad_keep_oe, fb_out, fold_out, chain_sum_output}, ex);
		@(posedge clk_sys);
	endtask

	// ====================================================================
	// Result watcher: every completed transfer retires the oldest note
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && exq.size() > 0) begin
			e = exq.pop_front();
			m = mkq.pop_front();
			check({pslverr, prdata} & m, e & m);
		end
	end

	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		errors = errors + 1;
		tally_and_finish;
	end

	// ====================================================================
	// Main sequence
	initial begin
		fz = 1'b0;
		qv = 1'b0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`CPLMC_CTRL_OFS, `CPLMC_CTRL_RST);
		rd(`CPLMC_TERMSEL_OFS, `CPLMC_TERMSEL_RST);
		stat(1'b0, 1'b0, 1'b0, 1'b0);
		apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
		apb(1'b1, 12'h020, xs(), {1'b1, 32'h0}, {1'b1, 32'h0});
		sig = xs();
		wr(`CPLMC_SIGN_OFS, sig);
		rd(`CPLMC_SIGN_OFS, {16'h0, sig[15:0]});
		wr(`CPLMC_SWM_BASE + 12'h004, 32'h5);
		wr(`CPLMC_MASK_BASE, 32'h1);
		wr(`CPLMC_MASK_BASE + 12'h010, 32'h2);
		wr(`CPLMC_TERMSEL_OFS, 32'h0011c121);
		// Every edge mode (D, T, JK, SR) against every xor source, random bus values
		for (n = 0; n < 12; n = n + 1) begin
			wr(`CPLMC_CTRL_OFS, (n % 3) | ((n % 4) << 4));
			drive(xs());
			xr = (n % 3 == 0) ? a : (n % 3 == 1) ? ~a : a ^ b;
			case (n % 4)
				0: qv = xr;
				1: qv = qv ^ xr;
				2: qv = (xr & ~qv) | (~b & qv);
				default: qv = xr ? 1'b1 : (b ? 1'b0 : qv);
			endcase
			pulse;
			stat(a, xr, a, qv);
		end
		// Latch passes while the clock is high, holds while low
		wr(`CPLMC_CTRL_OFS, 32'h40);
		shared_edge_source[0] <= 1'b1;
		drive(32'h1);
		stat(1'b1, 1'b1, 1'b1, 1'b1);
		shared_edge_source[0] <= 1'b0;
		drive(32'h0);
		stat(1'b0, 1'b0, 1'b0, 1'b1);
		// Enable term index 7 reads low, so the edge is ignored
		wr(`CPLMC_CTRL_OFS, 32'h200);
		pulse;
		stat(1'b0, 1'b0, 1'b0, 1'b1);
		wr(`CPLMC_CTRL_OFS, 32'h0);
		pulse;
		stat(1'b0, 1'b0, 1'b0, 1'b0);
		// Set from term 1, then shared clear on top of it
		wr(`CPLMC_CTRL_OFS, 32'h1400);
		drive(32'h20);
		stat(1'b0, 1'b0, 1'b0, 1'b1);
		shared_clear_line <= 1'b1;
		repeat (3) @(posedge clk_sys);
		stat(1'b0, 1'b0, 1'b0, 1'b0);
		shared_clear_line <= 1'b0;
		repeat (3) @(posedge clk_sys);
		stat(1'b0, 1'b0, 1'b0, 1'b1);
		// Chain input alone makes the sum true
		wr(`CPLMC_CTRL_OFS, 32'h40000);
		chain_sum_input <= 1'b1;
		drive(32'h0);
		stat(1'b1, 1'b1, 1'b0, 1'b1);
		// Fuse hides configuration, not signature or status
		wr(`CPLMC_FUSE_OFS, 32'h1);
		fz = 1'b1;
		rd(`CPLMC_CTRL_OFS, 32'h0);
		rd(`CPLMC_SIGN_OFS, {16'h0, sig[15:0]});
		stat(1'b1, 1'b1, 1'b0, 1'b1);
		// Output and feedback pick registered or direct on their own
		chain_sum_input <= 1'b0;
		wr(`CPLMC_CTRL_OFS, 32'h2000);
		look(7'b1000010);
		wr(`CPLMC_CTRL_OFS, 32'h4000);
		look(7'b0000110);
		// Driven high as an output, then released: the keeper holds the high level
		wr(`CPLMC_CTRL_OFS, 32'h180001);
		look(7'b1110110);
		pad_ext_drv <= 1'b0;
		wr(`CPLMC_CTRL_OFS, 32'h80000);
		look(7'b0011010);
		// Drive enable from the inverted first pin, then from a bus signal
		pad_ext_drv <= 1'b1;
		pad_i <= 1'b1;
		wr(`CPLMC_CTRL_OFS, 32'h208000);
		drive(32'h1000);
		look(7'b0010010);
		pad_i <= 1'b0;
		drive(32'h0);
		look(7'b0100010);
		wr(`CPLMC_CTRL_OFS, 32'h220000);
		drive(32'h1);
		look(7'b1110101);
		// Data from the separate term, then from the pin, while the xor path stays low
		wr(`CPLMC_CTRL_OFS, 32'h4);
		drive(32'h0);
		pulse;
		stat(1'b0, 1'b0, 1'b0, 1'b0);
		drive(32'h20);
		pulse;
		stat(1'b0, 1'b0, 1'b0, 1'b1);
		wr(`CPLMC_CTRL_OFS, 32'h8);
		pulse;
		stat(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge clk_sys);
		tally_and_finish;
	end
endmodule // cplmc_core_bench

bind cplmc_core cplmc_core_chk i_cplmc_core_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
